// ===== hw/dsc_capture.sv
// Clock sampling, command capture, write data capture and read data launch for a burst SRAM port.
`timescale 1ns/1ns
module dsc_capture
(
   input  wire logic                        clk,
   input  wire logic                        sys_rst,
   input  wire logic                        k_clk,
   input  wire logic                        k_clk_n,
   input  wire logic                        c_clk,
   input  wire logic                        c_clk_n,
   input  wire logic                        single_clk_mode,
   input  wire logic                        load_strobe_n,
   input  wire logic                        rd_wr_sel,
   input  wire logic [dsc_pkg::ADDR_W-1:0]  addr,
   input  wire logic [dsc_pkg::DATA_W-1:0]  dq_in,
   input  wire logic [dsc_pkg::DATA_W-1:0]  rd_word0,
   input  wire logic [dsc_pkg::DATA_W-1:0]  rd_word1,
   output logic                             cmd_valid,
   output logic                             cmd_read,
   output logic [dsc_pkg::ADDR_W-1:0]       cmd_addr,
   output logic                             wr_valid,
   output logic                             wr_beat,
   output logic [dsc_pkg::DATA_W-1:0]       wr_data,
   output logic [dsc_pkg::DATA_W-1:0]       dq_out,
   output logic                             dq_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.

   logic [3:0]                  clk_s1_reg;
   logic [3:0]                  clk_s2_reg;
   logic [3:0]                  clk_s3_reg;
   logic                        ld_s1_reg, ld_s2_reg;
   logic                        rw_s1_reg, rw_s2_reg;
   logic                        mode_s1_reg, mode_s2_reg;
   logic [dsc_pkg::ADDR_W-1:0]  a_s1_reg, a_s2_reg;
   logic [dsc_pkg::DATA_W-1:0]  d_s1_reg, d_s2_reg;
   logic [3:0]                  rise;

   // Every pin passes two flops; the third clock stage only serves edge detection.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         clk_s1_reg  <= dsc_pkg::SYNC_RST;  // Idle pin levels, or k_n and c_n would show a rise.
         clk_s2_reg  <= dsc_pkg::SYNC_RST;
         clk_s3_reg  <= dsc_pkg::SYNC_RST;
         ld_s1_reg   <= 1'b1;
         ld_s2_reg   <= 1'b1;
         rw_s1_reg   <= 1'b0;
         rw_s2_reg   <= 1'b0;
         mode_s1_reg <= 1'b0;
         mode_s2_reg <= 1'b0;
         a_s1_reg    <= dsc_pkg::ADDR_RST;
         a_s2_reg    <= dsc_pkg::ADDR_RST;
         d_s1_reg    <= dsc_pkg::DATA_RST;
         d_s2_reg    <= dsc_pkg::DATA_RST;
      end
      else
      begin
         clk_s1_reg  <= {c_clk_n, c_clk, k_clk_n, k_clk};
         clk_s2_reg  <= clk_s1_reg;
         clk_s3_reg  <= clk_s2_reg;
         ld_s1_reg   <= load_strobe_n;
         ld_s2_reg   <= ld_s1_reg;
         rw_s1_reg   <= rd_wr_sel;
         rw_s2_reg   <= rw_s1_reg;
         mode_s1_reg <= single_clk_mode;
         mode_s2_reg <= mode_s1_reg;
         a_s1_reg    <= addr;
         a_s2_reg    <= a_s1_reg;
         d_s1_reg    <= dq_in;
         d_s2_reg    <= d_s1_reg;
      end
   end

   // Rising edge of each clock pin, bit order k, k_n, c, c_n.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_rise
         assign rise[gi] = clk_s2_reg[gi] & ~clk_s3_reg[gi];
      end
   endgenerate

   logic k_rise, kn_rise, lp_rise, ln_rise;
   assign k_rise  = rise[0];
   assign kn_rise = rise[1];
   assign lp_rise = mode_s2_reg ? rise[0] : rise[2];
   assign ln_rise = mode_s2_reg ? rise[1] : rise[3];

   ////////////////////////////////////////////////////////////////////////////////
   // Command capture on the positive input clock only.

   dsc_pkg::dsc_state_t state_reg;
   logic                rd_pend_reg;

   // A new access is only ever opened on a positive input clock rise.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cmd_valid <= 1'b0;
         cmd_read  <= 1'b0;
         cmd_addr  <= dsc_pkg::ADDR_RST;
      end
      else
      begin
         cmd_valid <= k_rise & ~ld_s2_reg;
         if (k_rise & ~ld_s2_reg)
         begin
            cmd_read <= rw_s2_reg;
            cmd_addr <= a_s2_reg;
         end
      end
   end

   // Burst sequencer: a write takes the capture at its own command rise and the next one, a read the next two launches.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         state_reg <= dsc_pkg::DSC_IDLE;
      else
      begin
         unique case (state_reg)
            dsc_pkg::DSC_IDLE:
            begin
               if (k_rise & ~ld_s2_reg)
                  state_reg <= rw_s2_reg ? dsc_pkg::DSC_RD_BEAT : dsc_pkg::DSC_WR_BEAT;
            end
            dsc_pkg::DSC_WR_BEAT:
            begin
               if (kn_rise)
                  state_reg <= dsc_pkg::DSC_IDLE;      // Second word taken, burst of two done.
            end
            dsc_pkg::DSC_RD_BEAT:
            begin
               if (ln_rise & rd_pend_reg)
                  state_reg <= dsc_pkg::DSC_IDLE;
            end
            default:
               state_reg <= dsc_pkg::DSC_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write data capture, both input clocks.

   // Word 0 follows the command's own rise, word 1 the next negative clock rise.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         wr_valid <= 1'b0;
         wr_beat  <= 1'b0;
         wr_data  <= dsc_pkg::DATA_RST;
      end
      else
      begin
         wr_valid <= 1'b0;
         if ((state_reg == dsc_pkg::DSC_IDLE & k_rise & ~ld_s2_reg & ~rw_s2_reg)
            | (state_reg == dsc_pkg::DSC_WR_BEAT & kn_rise))
         begin
            wr_valid <= 1'b1;
            wr_beat  <= kn_rise;
            wr_data  <= d_s2_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data launch on the output clocks, or input clocks in single clock mode.

   // The first launch rise sends word 0; the next negative rise sends word 1 and ends the read.
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dq_out      <= dsc_pkg::DATA_RST;
         dq_oe       <= 1'b0;
         rd_pend_reg <= 1'b0;
      end
      else if (state_reg == dsc_pkg::DSC_RD_BEAT)
      begin
         if (lp_rise & ~rd_pend_reg)
         begin
            dq_out      <= rd_word0;
            dq_oe       <= 1'b1;
            rd_pend_reg <= 1'b1;
         end
         else if (ln_rise & rd_pend_reg)
            dq_out      <= rd_word1;
      end
      else
      begin
         if (lp_rise | ~rd_pend_reg)
            dq_oe       <= 1'b0;
         // A fresh command re-arms word 0 even while the last word still stands, because the
         // output clocks may lag the input clocks past the next command.
         if (lp_rise | ~rd_pend_reg | (k_rise & ~ld_s2_reg))
            rd_pend_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   a_cmd_on_k_rise: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_valid |-> $past(k_rise) && !$past(ld_s2_reg))
      else $error("Command opened without a positive clock rise.");

   a_cmd_dir_taken: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_valid |-> cmd_read == $past(rw_s2_reg))
      else $error("Command direction does not match the select.");

   a_cmd_addr_taken: assert property (@(posedge clk) disable iff (sys_rst)
      cmd_valid |-> cmd_addr == $past(a_s2_reg))
      else $error("Command address not captured on the rise.");

   a_wr_beat_edge: assert property (@(posedge clk) disable iff (sys_rst)
      wr_valid |-> (wr_beat ? $past(kn_rise) : $past(k_rise)))
      else $error("Write word captured on the wrong clock.");

   a_oe_only_read: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(dq_oe) |-> $past(state_reg) == dsc_pkg::DSC_RD_BEAT && $past(lp_rise))
      else $error("Read outputs enabled without a launch rise.");

   a_single_k_launch: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(dq_oe) && $past(mode_s2_reg) |-> $past(rise[0]))
      else $error("Single clock mode launch not on input clock.");

   a_wr_burst_two: assert property (@(posedge clk) disable iff (sys_rst)
      wr_valid && wr_beat |-> state_reg == dsc_pkg::DSC_IDLE)
      else $error("Write burst did not end after two words.");

   a_rd_release: assert property (@(posedge clk) disable iff (sys_rst)
      dq_oe && state_reg == dsc_pkg::DSC_IDLE && lp_rise |=> !dq_oe)
      else $error("Read outputs not released when idle.");

endmodule

// ===== hw/dsc_pkg.sv
// Package of constants for the burst SRAM clock and command capture block.
package dsc_pkg;
   localparam int DATA_W     = 18;
   localparam int ADDR_W     = 20;
   localparam int BURST_LEN  = 2;
   localparam int CLK_MHZ    = 50;
   localparam int LINK_NS    = 160;
   localparam int LINK_CYC   = (LINK_NS * CLK_MHZ) / 1000;
   localparam logic [3:0] SYNC_RST = 4'hA;  // Idle levels of c_n, c, k_n, k, so reset leaves no false edge.
   localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
   typedef enum logic [1:0] {DSC_IDLE = 2'h0, DSC_WR_BEAT = 2'h1, DSC_RD_BEAT = 2'h2} dsc_state_t;
endpackage

// ===== sim/dsc_capture_tb.sv
// Self-checking bench for the burst SRAM clock and command capture block.
`timescale 1ns/1ns
module dsc_capture_tb;
   logic                       clk, sys_rst, c_en, single_clk_mode, k_clk, k_clk_n, c_clk, c_clk_n;
   logic                       load_strobe_n, rd_wr_sel, cmd_valid, cmd_read, wr_valid, wr_beat, dq_oe;
   logic [dsc_pkg::ADDR_W-1:0] addr, cmd_addr;
   logic [dsc_pkg::DATA_W-1:0] dq_in, rd_word0, rd_word1, wr_data, dq_out;
   int                         fails = 0;
   int                         check_count = 0;
   dsc_capture uut (.clk, .sys_rst, .k_clk, .k_clk_n, .c_clk, .c_clk_n, .single_clk_mode, .load_strobe_n,
      .rd_wr_sel, .addr, .dq_in, .rd_word0, .rd_word1, .cmd_valid, .cmd_read, .cmd_addr, .wr_valid,
      .wr_beat, .wr_data, .dq_out, .dq_oe);
   dsc_ctrl_model ctl (.clk, .c_en, .k_clk, .k_clk_n, .c_clk, .c_clk_n, .load_strobe_n, .rd_wr_sel, .addr, .dq_in);
   ////////////////////////////////////////
   // Counts each comparison and reports a mismatch at once.
   task automatic check(input string name, input logic [31:0] seen, exp);
   begin
      check_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic results;
   begin
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   // Waits for a taken command; the synchronisers make the wait a few cycles.
   task automatic see_cmd(input logic rw, input logic [19:0] a);
      int n;
   begin
      for (n = 0; n < 12 && cmd_valid !== 1'b1; n++) @(negedge clk);
      check("cmd_valid", cmd_valid, 1);
      check("cmd_read", cmd_read, rw);
      check("cmd_addr", cmd_addr, a);
   end
   endtask
   // Write burst: word 0 with the command, word 1 at the negative clock rise.
   task automatic t_write(input logic [19:0] a, input logic [17:0] d0, d1);
      int n;
   begin
      fork
         ctl.frame(1'b0, 1'b0, a, d0, d1);
         begin
            see_cmd(1'b0, a);
            check("wr_beat0", {wr_valid, wr_beat}, 2);
            check("wr_data0", wr_data, d0);
            @(negedge clk);
            for (n = 0; n < 12 && wr_valid !== 1'b1; n++) @(negedge clk);
            check("wr_beat1", {wr_valid, wr_beat}, 3);
            check("wr_data1", wr_data, d1);
         end
      join
   end
   endtask
   ////////////////////////////////////////
   // Read burst; in two-clock mode the output clocks stay still until the command period is over.
   task automatic t_read(input logic single, input logic [17:0] d0, d1);
      int n;
      logic seen;
   begin
      single_clk_mode = single;
      c_en = 1'b0;
      rd_word0 = d0;
      rd_word1 = d1;
      seen = 1'b0;
      fork
         begin
            ctl.frame(1'b0, 1'b1, 20'hABCDE, ~d0, ~d1);
            c_en = ~single;
            ctl.frame(1'b1, 1'b0, 20'h00000, d0, d1);
            ctl.frame(1'b1, 1'b0, 20'h00000, d0, d1);
         end
         see_cmd(1'b1, 20'hABCDE);
         begin
            // The window ends just after where a launch from the input clocks would already show.
            if (!single) repeat (12) @(negedge clk) seen |= dq_oe;
            check("oe_before_c", seen, 0);
            for (n = 0; n < 24 && dq_oe !== 1'b1; n++) @(negedge clk);
            check("rd_word0", {dq_oe, dq_out}, {1'b1, d0});
            for (n = 0; n < 12 && dq_out === d0; n++) @(negedge clk);
            check("rd_word1", {dq_oe, dq_out}, {1'b1, d1});
            for (n = 0; n < 24 && dq_oe === 1'b1; n++) @(negedge clk);
            check("rd_release", dq_oe, 0);
         end
      join
   end
   endtask
   // Free-running system clock.
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Reset, then writes back to back and a read in each clock mode.
   initial
   begin
      sys_rst = 1'b1;
      c_en = 1'b0;
      single_clk_mode = 1'b1;
      rd_word0 = 18'h00000;
      rd_word1 = 18'h00000;
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge clk);
      t_write(20'h00001, 18'h3FFFF, 18'h00000);
      t_write(20'hFFFFE, 18'h15555, 18'h2AAAA);
      t_read(1'b1, 18'h12345, 18'h3CDEF);
      t_read(1'b0, 18'h0F0F0, 18'h30303);
      results;
   end
   // The sequence needs some 77 cycles; a thousand means a hang.
   initial
   begin
      #20000;
      fails++;
      results;
   end
endmodule

// ===== sim/dsc_ctrl_model.sv
// Behavioural memory controller driving both clock pairs, commands and write data.
`timescale 1ns/1ns
module dsc_ctrl_model
(
   input  wire logic                  clk,
   input  wire logic                  c_en,
   output logic                       k_clk,
   output logic                       k_clk_n,
   output logic                       c_clk,
   output logic                       c_clk_n,
   output logic                       load_strobe_n,
   output logic                       rd_wr_sel,
   output logic [dsc_pkg::ADDR_W-1:0] addr,
   output logic [dsc_pkg::DATA_W-1:0] dq_in
);
   logic [1:0] kd_reg = 2'h0;
   ////////////////////////////////////////
   // Output clocks trail the input clocks by two clock edges, so a launch from the wrong pair shows.
   always @(posedge clk) kd_reg <= {kd_reg[0], k_clk};
   assign c_clk = c_en & kd_reg[1];
   assign c_clk_n = ~c_clk;
   // Clocks stand still between periods and the strobe idles high.
   initial
   begin
      k_clk = 1'b0;
      k_clk_n = 1'b1;
      load_strobe_n = 1'b1;
      rd_wr_sel = 1'b0;
      addr = 20'h00000;
      dq_in = 18'h00000;
   end
   // One 160 ns input clock period when frames follow back to back; the strobe returns high, the other released lines show their inverse.
   task automatic frame(input logic ld_n, rw, input logic [19:0] a, input logic [17:0] d0, d1);
   begin
      @(negedge clk);
      k_clk = 1'b1;
      k_clk_n = 1'b0;
      load_strobe_n = ld_n;
      rd_wr_sel = rw;
      addr = a;
      dq_in = d0;
      repeat (dsc_pkg::LINK_CYC / 2) @(negedge clk);
      k_clk = 1'b0;
      k_clk_n = 1'b1;
      dq_in = d1;
      repeat (dsc_pkg::LINK_CYC / 2 - 1) @(negedge clk);
      load_strobe_n = 1'b1;
      rd_wr_sel = ~rw;
      addr = ~a;
      dq_in = ~d1;
   end
   endtask
endmodule
